//--- rtl/dcp_pkg.sv
// Package: register map, field layout and reset values of the progress block
package dcp_pkg;

  // ********************************************************
  // Register bus
  // ********************************************************
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;

  // ********************************************************
  // Per-channel register window: channel at CH_STRIDE * index
  // ********************************************************
  localparam logic [7:0] CH_STRIDE     = 8'h20;
  localparam logic [4:0] OFS_SRC_SIZE  = 5'h00;
  localparam logic [4:0] OFS_SRC_PTR   = 5'h04;
  localparam logic [4:0] OFS_DST_PTR   = 5'h08;
  localparam logic [4:0] OFS_CELL_SIZE = 5'h0c;
  localparam logic [4:0] OFS_CELL_PTR  = 5'h10;
  localparam logic [4:0] OFS_MATCH     = 5'h14;
  localparam logic [4:0] OFS_CTRL      = 5'h18;

  // ********************************************************
  // Field layout
  // ********************************************************
  localparam int PTR_W        = 16;
  localparam int MATCH_W      = 8;
  localparam int CTRL_PMODE   = 0;

  // ********************************************************
  // Values after reset
  // ********************************************************
  localparam logic [15:0] RST_PTR   = 16'h0000;
  localparam logic [15:0] RST_SIZE  = 16'h0000;
  localparam logic [7:0]  RST_MATCH = 8'h00;

  // ********************************************************
  // Defaults
  // ********************************************************
  localparam int NUM_CH_DEF = 4;
  localparam int BUF_DEPTH  = 2;

endpackage

//--- rtl/dcp_progress.sv
// Module: per-channel DMA progress pointers with a two-entry byte buffer
//
// Functional notes
// - Source byte pointer: 16 bits read-only, upper half reads zero, resets zero.
// - In pattern mode a match clears that channel's source and cell pointers.
// - Destination byte pointer is 16 bits read-only, gives byte offset reached.
// - Cell size is 16 bits read-write, resets zero, bytes moved per trigger.
// - Cell byte pointer is 16 bits read-only, counts within cell, resets zero.
// - Upper unimplemented bits of pointers and sizes ignore writes, read zero.
// - Pattern mode compares moved bytes with match byte, pulses pattern_hit on match.
// - Source block size is 16 bits read-write, counting bytes.
`timescale 1ns/1ps

module dcp_progress
  import dcp_pkg::*;
#(
  parameter int NUM_CH = NUM_CH_DEF,
  parameter int CW     = (NUM_CH > 1) ? $clog2(NUM_CH) : 1
)
(
  input  wire logic                     sys_clk,
  input  wire logic                     resetn,
  input  wire logic [dcp_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [dcp_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [dcp_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                     src_valid,
  output logic                          src_ready,
  input  wire logic [7:0]               src_data,
  input  wire logic [CW-1:0]            src_chan,
  output logic                          dst_valid,
  input  wire logic                     dst_ready,
  output logic      [7:0]               dst_data,
  output logic      [CW-1:0]            dst_chan,
  output logic      [NUM_CH-1:0]        pattern_hit,
  output logic      [NUM_CH-1:0]        cell_done
);
  import dcp_pkg::*;

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    logic [NUM_CH-1:0][15:0]  src_block_size;
    logic [NUM_CH-1:0][15:0]  src_byte_ptr;
    logic [NUM_CH-1:0][15:0]  dst_byte_ptr;
    logic [NUM_CH-1:0][15:0]  cell_byte_count;
    logic [NUM_CH-1:0][15:0]  cell_byte_ptr;
    logic [NUM_CH-1:0][7:0]   match_byte;
    logic [NUM_CH-1:0]        pmode;
    logic [1:0][CW+7:0]       mem;
    logic                     wp;
    logic                     rp;
    logic [1:0]               cnt;
    logic                     s_ready;
    logic                     m_valid;
    logic [7:0]               m_data;
    logic [CW-1:0]            m_chan;
    logic [DATA_W-1:0]        rdata;
    logic [NUM_CH-1:0]        hit;
    logic [NUM_CH-1:0]        cdone;
  } dcp_state_s;

  dcp_state_s q;
  dcp_state_s next_q;

  // ********************************************************
  // Address decode
  // ********************************************************
  // Channel window hit: address bits 7:5 equal the channel index
  function automatic logic chan_hit(input logic [ADDR_W-1:0] a,
                                    input int c);
    logic [ADDR_W-1:0] base;
    base = CH_STRIDE * ADDR_W'(c);
    chan_hit = (a[ADDR_W-1:5] == base[ADDR_W-1:5]);
  endfunction

  logic push;
  logic pop;
  logic [15:0] sp_inc;
  logic [15:0] cp_inc;

  always_comb
  begin
    next_q       = q;
    next_q.hit   = '0;
    next_q.cdone = '0;
    next_q.rdata = '0;
    sp_inc       = '0;
    cp_inc       = '0;
    push = src_valid && q.s_ready;
    pop  = q.m_valid && dst_ready;

    // ******************************************************
    // Two-entry buffer; full drops src_ready so nothing is lost
    // ******************************************************
    if (push)
    begin
      next_q.mem[q.wp] = {src_chan, src_data};
      next_q.wp        = ~q.wp;
    end
    if (pop)
    begin
      next_q.rp = ~q.rp;
    end
    next_q.cnt     = q.cnt + {1'b0, push} - {1'b0, pop};
    next_q.s_ready = (next_q.cnt != 2'(BUF_DEPTH));
    next_q.m_valid = (next_q.cnt != 2'd0);
    {next_q.m_chan, next_q.m_data} = next_q.mem[next_q.rp];

    // ******************************************************
    // Pointer tracking
    // ******************************************************
    for (int c = 0; c < NUM_CH; c++)
    begin
      // Source side: one step per byte taken in
      if (push && src_chan == CW'(c))
      begin
        sp_inc = q.src_byte_ptr[c] + 16'h0001;
        if (sp_inc == q.src_block_size[c])
          next_q.src_byte_ptr[c] = RST_PTR;
        else
          next_q.src_byte_ptr[c] = sp_inc;
      end
      // Destination side: one step per byte handed on
      if (pop && q.m_chan == CW'(c))
      begin
        next_q.dst_byte_ptr[c] = q.dst_byte_ptr[c] + 16'h0001;
        cp_inc = q.cell_byte_ptr[c] + 16'h0001;
        // Size zero wraps at 65,536 bytes
        if (cp_inc == q.cell_byte_count[c])
        begin
          next_q.cell_byte_ptr[c] = RST_PTR;
          next_q.cdone[c]         = 1'b1;
        end
        else
        begin
          next_q.cell_byte_ptr[c] = cp_inc;
        end
        // Match clear wins over a same-cycle source step
        if (q.pmode[c] && q.m_data == q.match_byte[c])
        begin
          next_q.src_byte_ptr[c]  = RST_PTR;
          next_q.cell_byte_ptr[c] = RST_PTR;
          next_q.hit[c]           = 1'b1;
        end
      end

      // ****************************************************
      // Register writes: only implemented bits are stored
      // ****************************************************
      if (reg_wr && chan_hit(reg_addr, c))
      begin
        case (reg_addr[4:0])
          OFS_SRC_SIZE:
            next_q.src_block_size[c] = reg_wdata[PTR_W-1:0];
          OFS_CELL_SIZE:
            next_q.cell_byte_count[c] = reg_wdata[PTR_W-1:0];
          OFS_MATCH:
            next_q.match_byte[c] = reg_wdata[MATCH_W-1:0];
          OFS_CTRL:
            next_q.pmode[c] = reg_wdata[CTRL_PMODE];
          default:
            ;
        endcase
      end

      // ****************************************************
      // Register reads: upper bits zero, unmapped reads zero
      // ****************************************************
      if (reg_rd && chan_hit(reg_addr, c))
      begin
        case (reg_addr[4:0])
          OFS_SRC_SIZE:
            next_q.rdata = {16'h0000, q.src_block_size[c]};
          OFS_SRC_PTR:
            next_q.rdata = {16'h0000, q.src_byte_ptr[c]};
          OFS_DST_PTR:
            next_q.rdata = {16'h0000, q.dst_byte_ptr[c]};
          OFS_CELL_SIZE:
            next_q.rdata = {16'h0000, q.cell_byte_count[c]};
          OFS_CELL_PTR:
            next_q.rdata = {16'h0000, q.cell_byte_ptr[c]};
          OFS_MATCH:
            next_q.rdata = {24'h000000, q.match_byte[c]};
          OFS_CTRL:
            next_q.rdata = {31'h00000000, q.pmode[c]};
          default:
            next_q.rdata = '0;
        endcase
      end
    end
  end

  // ********************************************************
  // State register
  // ********************************************************
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      q <= '0;
    else
      q <= next_q;
  end

  assign reg_rdata   = q.rdata;
  assign src_ready   = q.s_ready;
  assign dst_valid   = q.m_valid;
  assign dst_data    = q.m_data;
  assign dst_chan    = q.m_chan;
  assign pattern_hit = q.hit;
  assign cell_done   = q.cdone;

endmodule // dcp_progress

//--- test/dcp_progress_assertions.sv
// Checker: bus and stream assertions for the progress block
`timescale 1ns/1ps
module dcp_progress_chk
  import dcp_pkg::*;
#(parameter int NUM_CH = 4, parameter int CW = 2)
(
  input wire logic               sys_clk,
  input wire logic               resetn,
  input wire logic [ADDR_W-1:0]  reg_addr,
  input wire logic [DATA_W-1:0]  reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [DATA_W-1:0]  reg_rdata,
  input wire logic               src_valid,
  input wire logic               src_ready,
  input wire logic [7:0]         src_data,
  input wire logic [CW-1:0]      src_chan,
  input wire logic               dst_valid,
  input wire logic               dst_ready,
  input wire logic [7:0]         dst_data,
  input wire logic [CW-1:0]      dst_chan,
  input wire logic [NUM_CH-1:0]  pattern_hit,
  input wire logic [NUM_CH-1:0]  cell_done
);
  // Entries held by the buffer, tracked from both handshakes
  logic [1:0] fill;
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn) fill <= 2'h0;
    else fill <= fill + 2'(src_valid && src_ready) - 2'(dst_valid && dst_ready);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  chk_ptr_upper: assert property (
    $past(reg_rd) && $past(reg_addr[4:0]) <= 5'h10
      |-> reg_rdata[31:16] == 16'h0)
    else $error("upper pointer bits not zero");
  chk_match_upper: assert property (
    $past(reg_rd) && $past(reg_addr[4:0]) == 5'h14
      |-> reg_rdata[31:8] == 24'h0)
    else $error("upper match bits not zero");
  chk_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  chk_fill_valid: assert property (
    dst_valid == (fill != 2'h0))
    else $error("output valid disagrees with fill");
  chk_full_ready: assert property (
    fill == 2'h2 |-> !src_ready)
    else $error("ready while buffer full");
  chk_head_hold: assert property (
    dst_valid && !dst_ready
      |=> dst_valid && $stable(dst_data) && $stable(dst_chan))
    else $error("head changed while stalled");
  chk_hit_chan: assert property (
    pattern_hit != 0 |-> $past(dst_valid && dst_ready)
      && pattern_hit == NUM_CH'(1) << $past(dst_chan))
    else $error("match pulse without pop of its channel");
  chk_done_pop: assert property (
    cell_done != 0
      |-> $past(dst_valid && dst_ready) && $onehot(cell_done))
    else $error("cell end without a pop");
endmodule // dcp_progress_chk

bind dcp_progress dcp_progress_chk #(.NUM_CH(NUM_CH), .CW(CW)) chk_i (
  .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .src_valid(src_valid), .src_ready(src_ready),
  .src_data(src_data), .src_chan(src_chan), .dst_valid(dst_valid),
  .dst_ready(dst_ready), .dst_data(dst_data), .dst_chan(dst_chan),
  .pattern_hit(pattern_hit), .cell_done(cell_done));

//--- test/dma_channel_progress_pointers_tb.sv
// Testbench: register map and byte stream of the progress block
`timescale 1ns/1ps
module dma_channel_progress_pointers_tb;
  import dcp_pkg::*;
  logic        sys_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0]  reg_addr = 8'h00, src_data = 8'h00, dst_data;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic        src_valid = 0, src_ready, dst_valid, dst_ready = 0;
  logic [1:0]  src_chan = 2'h0, dst_chan;
  logic [3:0]  pattern_hit, cell_done;
  int          fail_count = 0, n_checks = 0, hits = 0, dones = 0;
  // Rows: address, write data, read back
  logic [71:0] rows [8] = '{{8'h0c, 32'hffffffff, 32'h0000ffff},
    {8'h20, 32'h1234abcd, 32'h0000abcd}, {8'h34, 32'hffffffa5, 32'ha5},
    {8'h44, 32'hffffffff, 32'h0}, {8'h68, 32'hffffffff, 32'h0},
    {8'h30, 32'hffffffff, 32'h0}, {8'h1c, 32'hffffffff, 32'h0},
    {8'h80, 32'hffffffff, 32'h0}};
  always #12.5 sys_clk = ~sys_clk;
  always @(negedge sys_clk)
  begin
    hits = hits + int'(pattern_hit[0]);
    dones = dones + int'(cell_done[0]);
  end
  dcp_progress #(.NUM_CH(4)) dcp_progress_i (.sys_clk(sys_clk),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .src_valid(src_valid), .src_ready(src_ready), .src_data(src_data),
    .src_chan(src_chan), .dst_valid(dst_valid), .dst_ready(dst_ready),
    .dst_data(dst_data), .dst_chan(dst_chan), .pattern_hit(pattern_hit),
    .cell_done(cell_done));
  // ****************************************
  // Bus and stream tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Bounded wait; a stuck handshake ends the run
  task automatic wait_hi(ref logic s);
    for (int i = 0; i < 50 && s !== 1'b1; i++) @(negedge sys_clk);
    if (s !== 1'b1)
    begin
      fail_count++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk) reg_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk) reg_rd <= 0;
    @(negedge sys_clk) chk("reg_rdata", exp, reg_rdata);
  endtask
  task automatic push(input logic [7:0] d, input logic [1:0] c);
    @(posedge sys_clk) {src_valid, src_data, src_chan} <= {1'b1, d, c};
    @(negedge sys_clk) wait_hi(src_ready);
    @(posedge sys_clk) src_valid <= 0;
  endtask
  task automatic pop(input logic [7:0] exp, input logic [1:0] ch);
    @(negedge sys_clk) wait_hi(dst_valid);
    chk("dst_data", {24'h0, exp}, {24'h0, dst_data});
    chk("dst_chan", {30'h0, ch}, {30'h0, dst_chan});
    @(posedge sys_clk) dst_ready <= 1;
    @(posedge sys_clk) dst_ready <= 0;
  endtask
  initial
  begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1;
    for (int i = 0; i <= 24; i += 4) rd(8'(i), 32'h0);
    foreach (rows[i])
    begin
      wr(rows[i][71:64], rows[i][63:32]);
      rd(rows[i][71:64], rows[i][31:0]);
    end
    wr(8'h0c, 32'h3);
    wr(8'h14, 32'h5a);
    wr(8'h18, 32'h1);
    @(posedge sys_clk) dst_ready <= 1;
    for (int i = 1; i <= 4; i++) push(8'(i), 2'h0);
    repeat (4) @(posedge sys_clk);
    rd(8'h04, 32'h4);
    rd(8'h08, 32'h4);
    rd(8'h10, 32'h1);
    chk("cell_done", 32'h1, 32'(dones));
    push(8'h5a, 2'h0);
    repeat (4) @(posedge sys_clk);
    rd(8'h04, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h08, 32'h5);
    chk("pattern_hit", 32'h1, 32'(hits));
    // Stalled receiver: both entries fill, nothing lost
    @(posedge sys_clk) dst_ready <= 0;
    push(8'h11, 2'h1);
    push(8'h22, 2'h1);
    @(negedge sys_clk) chk("src_ready", 32'h0, {31'h0, src_ready});
    pop(8'h11, 2'h1);
    pop(8'h22, 2'h1);
    rd(8'h28, 32'h2);
    rd(8'h24, 32'h2);
    @(posedge sys_clk) resetn <= 0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1;
    rd(8'h0c, 32'h0);
    rd(8'h08, 32'h0);
    finish_test();
  end
endmodule // dma_channel_progress_pointers_tb
